// ==== core/pit_regs.svh ====
`ifndef PIT_REGS_SVH
`define PIT_REGS_SVH

// ==========================================================
// Timing constants: periods in ns, clock ticks per major cycle, counts in major cycles
`define PIT_MAJOR_CYCLE_NS     250
`define PIT_CLK_PERIOD_NS      5
`define PIT_TICKS_PER_MAJOR    (`PIT_MAJOR_CYCLE_NS / `PIT_CLK_PERIOD_NS)
`define PIT_CYC_ONE            8'h01
`define PIT_CYC_TWO            8'h02
`define PIT_CYC_THREE          8'h03
`define PIT_CYC_FOUR           8'h04
`define PIT_CYC_FIVE           8'h05
`define PIT_CYC_SIX            8'h06
`define PIT_CYC_SEVEN          8'h07
`define PIT_CYC_TWELVE         8'h0C
`define PIT_BLK_RD_SETUP       8'h07
`define PIT_BLK_WR_SETUP       8'h06
`define PIT_BLK_CM_PER_WORD    8'h05
`define PIT_BLK_CH_SETUP       8'h05
`define PIT_CH_WORD_FAST       8'h01
`define PIT_CH_WORD_SLOW       8'h02
// Opcode field positions within a 12-bit instruction word
`define PIT_OP_HI              11
`define PIT_OP_LO              6
`define PIT_SUB_BIT            5

`endif

// ==== core/pit_pkg.sv ====
`default_nettype none

// ==========================================================
// Types shared by the timing sequencer
package pit_pkg;

    typedef enum logic [1:0] {
        PIT_IDLE = 2'b00,
        PIT_RUN  = 2'b01,
        PIT_WORD = 2'b11,
        PIT_DONE = 2'b10
    } pit_state_type;

    // Instruction issue request
    typedef struct packed {
        logic        valid;
        logic [11:0] instr;
        logic [11:0] word_count;
    } pit_issue_type;

    // Per-cycle environment conditions
    typedef struct packed {
        logic adu_conflict;
        logic cm_conflict;
        logic slot_conflict;
        logic resync_trip;
        logic channel_active;
    } pit_cond_type;

endpackage

`default_nettype wire

// ==== core/pit_sequencer.sv ====
// How it works
// - Everything is counted in 250 ns major cycles derived from the system clock.
// - Nominal counts assume no conflicts; conflict inputs stretch execution.
// - Long jump with indexed target takes 3 major cycles.
// - Return jump with indexed target takes 4 major cycles.
// - Relocation load takes 3 cycles, relocation store takes 4.
// - Exchange-jump requests take 2 cycles absent assembly unit conflict.
// - Direct replace add 4 cycles; replace add/subtract one 5 cycles.
// - Indirect ops 3 cycles; replace add 5; replace add/subtract one 6.
// - Indexed ops 4 cycles; replace add 6; replace add/subtract one 7.
// - Single-word central memory read takes 12 cycles without conflicts.
// - Single-word central memory write takes 6 cycles without conflicts.
// - Block memory read costs 7 setup cycles plus 5 per word.
// - Block memory write costs 6 setup cycles plus 5 per word.
// - Memory reads may add one extra rotation trip for resynchronization.
// - Channel test and flag instructions take 2 cycles.
// - Single-word channel I/O, activate, deactivate, function take 2 cycles.
// - Block channel I/O: 5 setup cycles plus 1 or 2 per word.
// - Slow per-word rate applies when communicating processors share the slot.
// - Block channel input ends at zero count or channel inactive.
`include "pit_regs.svh"
`default_nettype none

module pit_sequencer
    import pit_pkg::*;
#(
    parameter int TICKS_PER_MAJOR = `PIT_TICKS_PER_MAJOR,
    parameter int ROTATION_CYCLES = 10
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // Instruction issue
    input  wire pit_issue_type issue,
    input  wire pit_cond_type  cond,
    // Status
    output logic               busy_reg,
    output logic               done_reg,
    output logic               major_tick_reg,
    output logic [15:0]        cycles_used_reg
);

    // ==========================================================
    // Nominal cycle count decode
    function automatic logic [7:0] pit_base_cycles(input logic [11:0] ins);
        logic [5:0] op;
        op = ins[`PIT_OP_HI:`PIT_OP_LO];
        case (op)
            6'o01:                          pit_base_cycles = `PIT_CYC_THREE;
            6'o02:                          pit_base_cycles = `PIT_CYC_FOUR;
            6'o20, 6'o21, 6'o22, 6'o23:     pit_base_cycles = `PIT_CYC_TWO;
            6'o24:                          pit_base_cycles = `PIT_CYC_THREE;
            6'o25:                          pit_base_cycles = `PIT_CYC_FOUR;
            6'o26:                          pit_base_cycles = `PIT_CYC_TWO;
            6'o30, 6'o31, 6'o32, 6'o33, 6'o34:
                                            pit_base_cycles = `PIT_CYC_TWO;
            6'o35:                          pit_base_cycles = `PIT_CYC_FOUR;
            6'o36, 6'o37:                   pit_base_cycles = `PIT_CYC_FIVE;
            6'o40, 6'o41, 6'o42, 6'o43, 6'o44:
                                            pit_base_cycles = `PIT_CYC_THREE;
            6'o45:                          pit_base_cycles = `PIT_CYC_FIVE;
            6'o46, 6'o47:                   pit_base_cycles = `PIT_CYC_SIX;
            6'o50, 6'o51, 6'o52, 6'o53, 6'o54:
                                            pit_base_cycles = `PIT_CYC_FOUR;
            6'o55:                          pit_base_cycles = `PIT_CYC_SIX;
            6'o56, 6'o57:                   pit_base_cycles = `PIT_CYC_SEVEN;
            6'o60:                          pit_base_cycles = `PIT_CYC_TWELVE;
            6'o61:                          pit_base_cycles = `PIT_BLK_RD_SETUP;
            6'o62:                          pit_base_cycles = `PIT_CYC_SIX;
            6'o63:                          pit_base_cycles = `PIT_BLK_WR_SETUP;
            6'o64, 6'o65, 6'o66, 6'o67:     pit_base_cycles = `PIT_CYC_TWO;
            6'o70, 6'o72, 6'o74, 6'o75, 6'o76, 6'o77:
                                            pit_base_cycles = `PIT_CYC_TWO;
            6'o71, 6'o73:                   pit_base_cycles = `PIT_BLK_CH_SETUP;
            default:                        pit_base_cycles = `PIT_CYC_ONE;
        endcase
    endfunction

    // Block-transfer class decode
    function automatic logic pit_is_block(input logic [11:0] ins);
        logic [5:0] op;
        op = ins[`PIT_OP_HI:`PIT_OP_LO];
        pit_is_block = (op == 6'o61) || (op == 6'o63) || (op == 6'o71) || (op == 6'o73);
    endfunction

    function automatic logic pit_is_chan_block(input logic [11:0] ins);
        logic [5:0] op;
        op = ins[`PIT_OP_HI:`PIT_OP_LO];
        pit_is_chan_block = (op == 6'o71) || (op == 6'o73);
    endfunction

    function automatic logic pit_is_cm(input logic [11:0] ins);
        logic [5:0] op;
        op = ins[`PIT_OP_HI:`PIT_OP_LO];
        pit_is_cm = (op >= 6'o60) && (op <= 6'o63);
    endfunction

    function automatic logic pit_is_cm_read(input logic [11:0] ins);
        logic [5:0] op;
        op = ins[`PIT_OP_HI:`PIT_OP_LO];
        pit_is_cm_read = (op == 6'o60) || (op == 6'o61);
    endfunction

    // Per-word cost of a block transfer, used on entry and on every next word
    function automatic logic [7:0] pit_word_cost(input logic is_chan, input logic slot);
        if (is_chan) begin
            pit_word_cost = slot ? `PIT_CH_WORD_SLOW : `PIT_CH_WORD_FAST;
        end else begin
            pit_word_cost = `PIT_BLK_CM_PER_WORD;
        end
    endfunction

    localparam logic [15:0] TPM_LAST = 16'(TICKS_PER_MAJOR - 1);
    localparam logic [7:0]  ROT_CNT  = 8'(ROTATION_CYCLES);

    // ==========================================================
    // Major cycle timebase
    logic [15:0]   tick_cnt_reg;
    logic          tick;
    pit_state_type state_reg;
    logic [11:0]   instr_reg;
    logic [7:0]    remain_reg;
    logic [11:0]   words_reg;
    logic [7:0]    word_left_reg;
    logic          resync_pend_reg;
    logic          resync_used_reg;

    assign tick = (tick_cnt_reg == TPM_LAST);

    // Divide clk_sys into 250 ns major cycles
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick || state_reg == PIT_IDLE) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    // Stalls from conflicts that hold the counters
    logic stall;
    logic chan_blk;
    logic blk_end;
    logic last_word;
    logic resync_ok;
    always_comb begin
        chan_blk  = pit_is_chan_block(instr_reg);
        stall     = cond.adu_conflict || (pit_is_cm(instr_reg) && cond.cm_conflict);
        blk_end   = (words_reg == 12'h000) || (chan_blk && !cond.channel_active);
        last_word = (words_reg == 12'h001) || (chan_blk && !cond.channel_active);
        // Only one rotation trip per memory read, however long the trip request stays up
        resync_ok = pit_is_cm_read(instr_reg) && !resync_used_reg
                    && (resync_pend_reg || cond.resync_trip);
    end

    // ==========================================================
    // Sequencer state machine
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg       <= PIT_IDLE;
            instr_reg       <= 12'h000;
            remain_reg      <= 8'h00;
            words_reg       <= 12'h000;
            word_left_reg   <= 8'h00;
            resync_pend_reg <= 1'b0;
            resync_used_reg <= 1'b0;
        end else begin
            case (state_reg)
                PIT_IDLE: begin
                    if (issue.valid) begin
                        instr_reg       <= issue.instr;
                        remain_reg      <= pit_base_cycles(issue.instr);
                        words_reg       <= pit_is_block(issue.instr) ? issue.word_count : 12'h000;
                        resync_pend_reg <= 1'b0;
                        resync_used_reg <= 1'b0;
                        state_reg       <= PIT_RUN;
                    end
                end
                PIT_RUN: begin
                    if (pit_is_cm_read(instr_reg) && cond.resync_trip && !resync_used_reg) begin
                        resync_pend_reg <= 1'b1;
                    end
                    if (tick && !stall) begin
                        if (remain_reg > 8'h01) begin
                            remain_reg <= remain_reg - 8'h01;
                        end else if (!blk_end) begin
                            state_reg     <= PIT_WORD;
                            word_left_reg <= pit_word_cost(chan_blk, cond.slot_conflict);
                        end else if (resync_ok) begin
                            resync_pend_reg <= 1'b0;
                            resync_used_reg <= 1'b1;
                            remain_reg      <= ROT_CNT;
                        end else begin
                            state_reg <= PIT_DONE;
                        end
                    end
                end
                PIT_WORD: begin
                    if (tick && !stall) begin
                        if (word_left_reg > 8'h01) begin
                            word_left_reg <= word_left_reg - 8'h01;
                        end else begin
                            words_reg <= words_reg - 12'h001;
                            if (!last_word) begin
                                // Next word starts at once, no idle cycle between words
                                word_left_reg <= pit_word_cost(chan_blk, cond.slot_conflict);
                            end else if (resync_ok) begin
                                resync_pend_reg <= 1'b0;
                                resync_used_reg <= 1'b1;
                                remain_reg      <= ROT_CNT;
                                state_reg       <= PIT_RUN;
                            end else begin
                                state_reg <= PIT_DONE;
                            end
                        end
                    end
                end
                PIT_DONE: begin
                    state_reg <= PIT_IDLE;
                end
                default: begin
                    state_reg <= PIT_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered status outputs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy_reg        <= 1'b0;
            done_reg        <= 1'b0;
            major_tick_reg  <= 1'b0;
            cycles_used_reg <= 16'h0000;
        end else begin
            busy_reg       <= (state_reg == PIT_RUN) || (state_reg == PIT_WORD);
            done_reg       <= (state_reg == PIT_DONE);
            major_tick_reg <= tick;
            if (state_reg == PIT_IDLE && issue.valid) begin
                cycles_used_reg <= 16'h0000;
            end else if (tick && (state_reg == PIT_RUN || state_reg == PIT_WORD)) begin
                cycles_used_reg <= cycles_used_reg + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Checks
    a_idle_no_tick: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_IDLE) |=> (tick_cnt_reg == 16'h0000))
        else $error("timebase ran while idle");
    a_pass_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_IDLE && issue.valid && issue.instr[11:6] == 6'o00)
        |=> (remain_reg == 8'h01))
        else $error("pass not one cycle");
    a_cm_read_twelve: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_IDLE && issue.valid && issue.instr[11:6] == 6'o60)
        |=> (remain_reg == 8'h0C))
        else $error("memory read count wrong");
    a_word_dec: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_WORD && tick && !stall && word_left_reg == 8'h01)
        |=> (words_reg == $past(words_reg) - 12'h001))
        else $error("word count not decremented");
    a_stall_holds: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_RUN && stall) |=> (remain_reg == $past(remain_reg)))
        else $error("conflict did not stall");
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_DONE) |=> (state_reg == PIT_IDLE && done_reg))
        else $error("done not reported");
    a_slow_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_RUN && tick && !stall && remain_reg == 8'h01 && !blk_end
         && chan_blk && cond.slot_conflict) |=> (word_left_reg == 8'h02))
        else $error("conflict word rate wrong");
    a_fast_rate: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_RUN && tick && !stall && remain_reg == 8'h01 && !blk_end
         && chan_blk && !cond.slot_conflict) |=> (word_left_reg == 8'h01))
        else $error("nonconflict word rate wrong");
    a_exchange_two: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_IDLE && issue.valid && issue.instr[11:6] == 6'o26)
        |=> (remain_reg == 8'h02))
        else $error("exchange request count wrong");
    a_trip_once: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_RUN && tick && !stall && remain_reg == 8'h01 && blk_end
         && resync_used_reg) |=> (state_reg == PIT_DONE))
        else $error("second rotation trip taken");
    a_word_slow: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_WORD && tick && !stall && word_left_reg == 8'h01 && !last_word
         && chan_blk && cond.slot_conflict) |=> (state_reg == PIT_WORD && word_left_reg == 8'h02))
        else $error("next word conflict rate wrong");
    a_block_stop: assert property (@(posedge clk_sys) disable iff (reset)
        (state_reg == PIT_WORD && tick && !stall && word_left_reg == 8'h01 && last_word
         && !resync_ok) |=> (state_reg == PIT_DONE))
        else $error("block did not end");

endmodule

`default_nettype wire

// ==== sim/pit_far_side.sv ====
`default_nettype none

// ==========================================================
// Far side: assembly unit, central memory and channel peer
module pit_far_side
    import pit_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // Scenario controls from the bench
    input  wire logic [3:0]   knob,
    input  wire logic [7:0]   stall_len,
    input  wire logic         start,
    // Conditions seen by the sequencer
    output var pit_cond_type  cond
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] stall_reg;

    // Shared unit stays busy for a set count after each issue
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stall_reg <= 8'h00;
        end else if (start) begin
            stall_reg <= stall_len;
        end else if (stall_reg != 8'h00) begin
            stall_reg <= stall_reg - 8'h01;
        end
    end

    // Knob bits: slot clash, resync trip, channel up, stall on memory
    always_comb begin
        cond.adu_conflict   = (stall_reg != 8'h00) && !knob[3];
        cond.cm_conflict    = (stall_reg != 8'h00) && knob[3];
        cond.slot_conflict  = knob[0];
        cond.resync_trip    = knob[1];
        cond.channel_active = knob[2];
    end
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none

// ==========================================================
// Self-checking bench for the timing sequencer
module testbench
    import pit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TPM = 3;
    localparam int ROT = 4;
    logic          clk_sys, reset, start;
    pit_issue_type issue;
    pit_cond_type  cond;
    logic [3:0]    knob;
    logic [7:0]    stall_len;
    logic          busy_reg, done_reg, major_tick_reg;
    logic [15:0]   cycles_used_reg;
    logic [15:0]   exp_q[$];
    logic [15:0]   tick_count;
    logic [31:0]   rng;
    int            bad_count, comparisons;

    pit_sequencer #(.TICKS_PER_MAJOR(TPM), .ROTATION_CYCLES(ROT)) DUT (
        .clk_sys(clk_sys), .reset(reset), .issue(issue), .cond(cond), .busy_reg(busy_reg),
        .done_reg(done_reg), .major_tick_reg(major_tick_reg), .cycles_used_reg(cycles_used_reg));
    pit_far_side far (
        .clk_sys(clk_sys), .reset(reset), .knob(knob), .stall_len(stall_len), .start(start),
        .cond(cond));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Nominal major cycles per opcode (hex of the octal codes)
    function automatic logic [15:0] nominal(input logic [5:0] op, input logic [11:0] wc,
                                            input logic [3:0] k);
        case (op) inside
            6'h01, 6'h14, [6'h20:6'h24]: return 16'h0003;
            6'h02, 6'h15, 6'h1D, [6'h28:6'h2C]: return 16'h0004;
            6'h1E, 6'h1F, 6'h25: return 16'h0005;
            6'h26, 6'h27, 6'h2D, 6'h32: return 16'h0006;
            6'h2E, 6'h2F: return 16'h0007;
            6'h30: return 16'h000C + (k[1] ? 16'(ROT) : 16'h0000);
            6'h31: return 16'h0007 + 16'(5 * wc) + (k[1] ? 16'(ROT) : 16'h0000);
            6'h33: return 16'h0006 + 16'(5 * wc);
            6'h39, 6'h3B: return 16'h0005 + (k[2] ? 16'(wc) * (k[0] ? 16'h0002 : 16'h0001)
                                                  : 16'h0000);
            [6'h10:6'h13], 6'h16, [6'h18:6'h1C], [6'h34:6'h38], 6'h3A, [6'h3C:6'h3F]:
                return 16'h0002;
            default: return 16'h0001;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One instruction: issue, optional stall probe and refused poke, wait done
    task automatic run_op(input logic [5:0] op, input logic [11:0] wc, input logic [3:0] k,
                          input logic [7:0] st, input bit poke);
        int n;
        n = 0;
        rng = xorshift(rng);
        knob = k;
        stall_len = st;
        start = 1'b1;
        issue = '{1'b1, {op, rng[5:0]}, wc};
        // Each major cycle that falls inside the stall window is charged on top
        exp_q.push_back(nominal(op, wc, k) + 16'(st / TPM));
        @(negedge clk_sys);
        issue.valid = 1'b0;
        start = 1'b0;
        if (poke) begin
            repeat (2 * TPM) @(negedge clk_sys);
            issue.valid = 1'b1;
            @(negedge clk_sys);
            issue.valid = 1'b0;
        end
        if (st != 8'h00) begin
            repeat (14) @(negedge clk_sys);
            check("busy during stall", {15'h0000, busy_reg}, 16'h0001);
        end
        while (done_reg !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000) begin
            bad_count++;
            tally_and_finish();
        end
        repeat (2) @(negedge clk_sys);
    endtask

    // Result watcher: oldest note against each completion
    always @(negedge clk_sys) begin
        if (major_tick_reg === 1'b1) begin
            tick_count = tick_count + 16'h0001;
        end
        if (done_reg === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra completion", 16'h0001, 16'h0000);
            end else begin
                check("cycles used", cycles_used_reg, exp_q[0]);
                check("major ticks", tick_count, exp_q.pop_front());
            end
            tick_count = 16'h0000;
        end
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        issue = '0;
        knob = 4'h4;
        stall_len = 8'h00;
        start = 1'b0;
        rng = 32'h5CC0;
        tick_count = 16'h0000;
        bad_count = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        // Every opcode, random block counts of zero to three
        for (int op = 0; op < 64; op++) begin
            run_op(op[5:0], {10'h000, rng[9:8]}, 4'h4, 8'h00, 1'b0);
        end
        // Block channel transfers, random slot clash
        for (int i = 0; i < 8; i++) begin
            run_op(i[0] ? 6'h39 : 6'h3B, {9'h000, rng[12:10]}, {3'b010, rng[13]}, 8'h00, 1'b0);
        end
        // Channel down: setup only
        run_op(6'h39, 12'h005, 4'h0, 8'h00, 1'b0);
        run_op(6'h3B, 12'h005, 4'h1, 8'h00, 1'b0);
        // Resynchronization trip on memory reads
        run_op(6'h30, 12'h000, 4'h6, 8'h00, 1'b0);
        run_op(6'h31, 12'h002, 4'h6, 8'h00, 1'b0);
        // Assembly unit and memory stalls, then a refused issue
        run_op(6'h16, 12'h000, 4'h4, 8'h14, 1'b0);
        run_op(6'h30, 12'h000, 4'hC, 8'h14, 1'b0);
        run_op(6'h30, 12'h000, 4'h4, 8'h00, 1'b1);
        check("pending notes", 16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule

`default_nettype wire
